// ---- pde_pkg.sv ----
// package: register map, field layout and state record of the dma engine
package pde_pkg;
    localparam logic [3:0] PDE_OFS_CONTROL = 4'h0;
    localparam logic [3:0] PDE_OFS_ENABLE = 4'h1;
    localparam logic [3:0] PDE_OFS_EVT_ENA = 4'h2;
    localparam logic [3:0] PDE_OFS_EVT = 4'h3;
    localparam logic [3:0] PDE_OFS_SRC_L = 4'h4;
    localparam logic [3:0] PDE_OFS_SRC_U = 4'h5;
    localparam logic [3:0] PDE_OFS_DST_L = 4'h6;
    localparam logic [3:0] PDE_OFS_DST_U = 4'h7;
    localparam logic [3:0] PDE_OFS_IO_L = 4'h8;
    localparam logic [3:0] PDE_OFS_IO_U = 4'h9;
    localparam logic [3:0] PDE_OFS_LEN_L = 4'ha;
    localparam logic [3:0] PDE_OFS_LEN_H = 4'hb;
    localparam logic [3:0] PDE_OFS_PROG_L = 4'hc;
    localparam logic [3:0] PDE_OFS_PROG_H = 4'hd;
    localparam logic [3:0] PDE_OFS_DATA = 4'he;
    localparam logic [3:0] PDE_OFS_THRESH = 4'hf;
    // bit positions, flow source count and buffer sizes
    localparam int PDE_CTRL_SRST_BIT = 0;
    localparam int PDE_CTRL_EN_BIT = 1;
    localparam int PDE_START_BIT = 0;
    localparam int PDE_STOP_BIT = 1;
    localparam int PDE_FLAG_DONE = 0;
    localparam int PDE_FLAG_FULL = 1;
    localparam int PDE_FLAG_DAVAIL = 2;
    localparam int PDE_MODE_LSB = 3;
    localparam int PDE_SIZE_LSB = 5;
    localparam int PDE_DIR_BIT = 7;
    localparam int PDE_FCTRL_LSB = 4;
    localparam logic [3:0] PDE_FLOW_SRCS = 4'h5;
    localparam logic [9:0] PDE_BUF_MIN = 10'h040;
    localparam int PDE_BUF_DEPTH = 512;
    typedef enum logic [1:0] {
        PDE_MODE_PUSH = 2'b00,
        PDE_MODE_PULL = 2'b01,
        PDE_MODE_COPY = 2'b10,
        PDE_MODE_FIFO = 2'b11
    } pde_mode_e;
    typedef enum logic [1:0] {
        PDE_ST_IDLE = 2'b00,
        PDE_ST_FETCH = 2'b01,
        PDE_ST_STORE = 2'b10
    } pde_phase_e;
    typedef struct packed {
        logic req;
        logic we;
        logic [14:0] addr;
        logic [7:0] wdata;
    } pde_mem_s;
    typedef struct packed {
        logic req;
        logic we;
        logic [8:0] addr;
        logic [7:0] wdata;
    } pde_io_s;
    // engine state apart from the buffer memory; every field resets to zero
    typedef struct packed {
        logic en;
        logic stop;
        logic [1:0] size;
        pde_mode_e mode;
        logic [2:0] ien;
        logic [2:0] flag;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] ioa;
        logic [13:0] len;
        logic [13:0] prog;
        logic [7:0] data;
        logic [5:0] thresh;
        pde_phase_e phase;
        logic [14:0] src_cur;
        logic [14:0] dst_cur;
        logic [9:0] fill;
        logic [8:0] wr_idx;
        logic [8:0] rd_idx;
        pde_mem_s mem;
        pde_io_s per;
        logic [7:0] rdata;
        logic summary;
        logic irq;
    } pde_regs_s;
endpackage

// ---- pde_engine.sv ----
// one byte-wide peripheral dma engine with its i/o-mapped registers
// What this block does
// - keep 14-bit programmed length, high six bits read/write in own register
// - read-only 14-bit progress count, low byte plus six-bit high field
// - eight-bit read/write data port onto the buffer, reset zero
// - six-bit almost-full threshold, read/write, reset zero
// - push and pull stop after one transfer; fifo mode runs on
// - push moves memory to i/o; pull and fifo move i/o to memory
// - push mode raises only the completion event
// - fifo mode also flags when fill level reaches threshold
// - start bit write launches the transfer with no further help
// - one summary bit per engine, cleared by the summary_clear_i input
// - interrupt leaves on external-0 line, gated by global enables
// - mode 00 push, 01 pull, 10 memory copy, 11 fifo
// - flow selector 0..4 picks pacing source; 5..15 never ready
// - enable bit gates engine; soft reset self-clears and reads zero
module pde_engine (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [3:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output pde_pkg::pde_mem_s mem_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    output pde_pkg::pde_io_s per_o,
    input wire logic [7:0] per_rdata_i,
    input wire logic [4:0] flow_ready_i,
    input wire logic ie_global_i,
    input wire logic ie_ext0_i,
    input wire logic summary_clear_i,
    output logic summary_event_o,
    output logic ext_int0_o,
    output logic busy_o
);
    pde_pkg::pde_regs_s r_r;
    pde_pkg::pde_regs_s r_nxt;
    logic [7:0] buf_mem [0:pde_pkg::PDE_BUF_DEPTH-1];
    logic buf_we;
    logic src_mem;
    logic dst_mem;
    logic fetch_done;
    logic store_done;
    logic fifo_full;
    logic hold;
    logic pop;
    logic srst;
    logic [9:0] size_b;

    function automatic logic [14:0] step(input logic [15:0] a,
                                         input logic [14:0] cur);
        step = a[pde_pkg::PDE_DIR_BIT+8] ? cur - 15'h0001 : cur + 15'h0001;
    endfunction

    function automatic logic [9:0] size_of(input logic [1:0] code);
        size_of = pde_pkg::PDE_BUF_MIN << code;
    endfunction

    function automatic logic flow_ok(input logic [3:0] sel,
                                     input logic [4:0] rdy);
        flow_ok = (sel < pde_pkg::PDE_FLOW_SRCS) ? rdy[sel[2:0]] : 1'b0;
    endfunction

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    assign io_rdata_o = r_r.rdata;
    assign mem_o = r_r.mem;
    assign per_o = r_r.per;
    assign summary_event_o = r_r.summary;
    assign ext_int0_o = r_r.irq;
    assign busy_o = (r_r.phase != pde_pkg::PDE_ST_IDLE);

    always_comb begin
        r_nxt = r_r;
        srst = io_wr_i && hit(io_addr_i, pde_pkg::PDE_OFS_CONTROL)
            && io_wdata_i[pde_pkg::PDE_CTRL_SRST_BIT];
        size_b = size_of(r_r.size);
        src_mem = (r_r.mode == pde_pkg::PDE_MODE_PUSH)
            || (r_r.mode == pde_pkg::PDE_MODE_COPY);
        dst_mem = (r_r.mode != pde_pkg::PDE_MODE_PUSH);
        fetch_done = (r_r.phase == pde_pkg::PDE_ST_FETCH) && (src_mem
            ? (r_r.mem.req && mem_ack_i)
            : (r_r.per.req && flow_ok(r_r.ioa[15:12], flow_ready_i)));
        store_done = (r_r.phase == pde_pkg::PDE_ST_STORE) && (dst_mem
            ? (r_r.mem.req && mem_ack_i)
            : (r_r.per.req && flow_ok(r_r.ioa[15:12], flow_ready_i)));
        fifo_full = (r_r.fill == size_b);
        pop = io_rd_i && hit(io_addr_i, pde_pkg::PDE_OFS_DATA)
            && (r_r.mode == pde_pkg::PDE_MODE_FIFO) && (r_r.fill != 10'h000);
        buf_we = 1'b0;
        // register writes
        if (io_wr_i) begin
            case (io_addr_i)
                pde_pkg::PDE_OFS_CONTROL:
                    r_nxt.en = io_wdata_i[pde_pkg::PDE_CTRL_EN_BIT];
                pde_pkg::PDE_OFS_ENABLE:
                    r_nxt.stop = io_wdata_i[pde_pkg::PDE_STOP_BIT];
                pde_pkg::PDE_OFS_EVT_ENA: begin
                    r_nxt.size = io_wdata_i[pde_pkg::PDE_SIZE_LSB +: 2];
                    r_nxt.mode = pde_pkg::pde_mode_e'(
                        io_wdata_i[pde_pkg::PDE_MODE_LSB +: 2]);
                    r_nxt.ien = io_wdata_i[2:0];
                end
                pde_pkg::PDE_OFS_EVT:
                    r_nxt.flag = r_r.flag & ~io_wdata_i[2:0];
                pde_pkg::PDE_OFS_SRC_L: r_nxt.src[7:0] = io_wdata_i;
                pde_pkg::PDE_OFS_SRC_U: r_nxt.src[15:8] = io_wdata_i;
                pde_pkg::PDE_OFS_DST_L: r_nxt.dst[7:0] = io_wdata_i;
                pde_pkg::PDE_OFS_DST_U: r_nxt.dst[15:8] = io_wdata_i;
                pde_pkg::PDE_OFS_IO_L: r_nxt.ioa[7:0] = io_wdata_i;
                pde_pkg::PDE_OFS_IO_U:
                    r_nxt.ioa[15:8] = {io_wdata_i[7:4], 3'h0, io_wdata_i[0]};
                pde_pkg::PDE_OFS_LEN_L: r_nxt.len[7:0] = io_wdata_i;
                pde_pkg::PDE_OFS_LEN_H:
                    r_nxt.len[13:8] = io_wdata_i[5:0];
                pde_pkg::PDE_OFS_DATA: r_nxt.data = io_wdata_i;
                pde_pkg::PDE_OFS_THRESH:
                    r_nxt.thresh = io_wdata_i[5:0];
                default: ;
            endcase
        end
        // transfer sequencer
        case (r_r.phase)
            pde_pkg::PDE_ST_IDLE: begin
                if (io_wr_i && hit(io_addr_i, pde_pkg::PDE_OFS_ENABLE)
                    && io_wdata_i[pde_pkg::PDE_START_BIT] && r_r.en
                    && !io_wdata_i[pde_pkg::PDE_STOP_BIT]) begin
                    r_nxt.prog = 14'h0000;
                    r_nxt.src_cur = r_r.src[14:0];
                    r_nxt.dst_cur = r_r.dst[14:0];
                    if (r_r.mode != pde_pkg::PDE_MODE_FIFO
                        && r_r.len == 14'h0000) begin
                        r_nxt.flag[pde_pkg::PDE_FLAG_DONE] = 1'b1;
                    end else begin
                        r_nxt.phase = pde_pkg::PDE_ST_FETCH;
                    end
                end
            end
            pde_pkg::PDE_ST_FETCH: begin
                if (!r_r.en || r_r.stop) begin
                    r_nxt.phase = pde_pkg::PDE_ST_IDLE;
                end else if (fetch_done) begin
                    r_nxt.data = src_mem ? mem_rdata_i : per_rdata_i;
                    r_nxt.phase = pde_pkg::PDE_ST_STORE;
                    if (src_mem) begin
                        r_nxt.src_cur = step(r_r.src, r_r.src_cur);
                    end
                end
            end
            pde_pkg::PDE_ST_STORE: begin
                if (store_done) begin
                    r_nxt.prog = r_r.prog + 14'h0001;
                    if (r_r.mode == pde_pkg::PDE_MODE_FIFO) begin
                        buf_we = 1'b1;
                        r_nxt.wr_idx = (r_r.wr_idx + 9'h001)
                            & 9'(size_b - 10'h001);
                    end else if (dst_mem) begin
                        r_nxt.dst_cur = step(r_r.dst, r_r.dst_cur);
                    end
                    // one-shot modes end here, fifo mode never does
                    if (r_r.mode != pde_pkg::PDE_MODE_FIFO
                        && r_r.prog + 14'h0001 == r_r.len) begin
                        r_nxt.flag[pde_pkg::PDE_FLAG_DONE] = 1'b1;
                        r_nxt.phase = pde_pkg::PDE_ST_IDLE;
                    end else if (!r_r.en || r_r.stop) begin
                        r_nxt.phase = pde_pkg::PDE_ST_IDLE;
                    end else begin
                        r_nxt.phase = pde_pkg::PDE_ST_FETCH;
                    end
                end else if (!r_r.en || r_r.stop) begin
                    r_nxt.phase = pde_pkg::PDE_ST_IDLE;
                end
            end
            default: r_nxt.phase = pde_pkg::PDE_ST_IDLE;
        endcase
        // buffer fill bookkeeping
        r_nxt.fill = r_r.fill + {9'h000, buf_we} - {9'h000, pop};
        if (pop) begin
            r_nxt.rd_idx = (r_r.rd_idx + 9'h001) & 9'(size_b - 10'h001);
        end
        if (r_r.mode != pde_pkg::PDE_MODE_PUSH) begin
            if (r_nxt.fill == size_b && !fifo_full) begin
                r_nxt.flag[pde_pkg::PDE_FLAG_FULL] = 1'b1;
            end
            if (r_nxt.fill == {4'h0, r_r.thresh} && buf_we
                && r_r.thresh != 6'h00) begin
                r_nxt.flag[pde_pkg::PDE_FLAG_DAVAIL] = 1'b1;
            end
        end
        // a full buffer stalls reception until software drains it
        hold = (r_r.mode == pde_pkg::PDE_MODE_FIFO) && (r_nxt.fill == size_b);
        // bus requests follow the next phase
        r_nxt.mem.req = ((r_nxt.phase == pde_pkg::PDE_ST_FETCH) && src_mem)
            || ((r_nxt.phase == pde_pkg::PDE_ST_STORE) && dst_mem && !hold);
        r_nxt.mem.we = (r_nxt.phase == pde_pkg::PDE_ST_STORE);
        r_nxt.mem.addr = (r_nxt.phase == pde_pkg::PDE_ST_FETCH)
            ? r_nxt.src_cur
            : ((r_r.mode == pde_pkg::PDE_MODE_FIFO)
                ? r_r.dst[14:0] + {6'h00, r_nxt.wr_idx} : r_nxt.dst_cur);
        r_nxt.mem.wdata = r_nxt.data;
        r_nxt.per.req = ((r_nxt.phase == pde_pkg::PDE_ST_FETCH) && !src_mem)
            || ((r_nxt.phase == pde_pkg::PDE_ST_STORE) && !dst_mem);
        r_nxt.per.we = (r_nxt.phase == pde_pkg::PDE_ST_STORE);
        r_nxt.per.addr = r_r.ioa[8:0];
        r_nxt.per.wdata = r_nxt.data;
        // read mux; count high reads back only its six live bits
        if (io_rd_i) begin
            case (io_addr_i)
                pde_pkg::PDE_OFS_CONTROL: r_nxt.rdata = {6'h00, r_r.en, 1'b0};
                pde_pkg::PDE_OFS_ENABLE: r_nxt.rdata = {6'h00, r_r.stop, 1'b0};
                pde_pkg::PDE_OFS_EVT_ENA:
                    r_nxt.rdata = {1'b0, r_r.size, r_r.mode, r_r.ien};
                pde_pkg::PDE_OFS_EVT: r_nxt.rdata = {5'h00, r_r.flag};
                pde_pkg::PDE_OFS_SRC_L: r_nxt.rdata = r_r.src[7:0];
                pde_pkg::PDE_OFS_SRC_U: r_nxt.rdata = r_r.src[15:8];
                pde_pkg::PDE_OFS_DST_L: r_nxt.rdata = r_r.dst[7:0];
                pde_pkg::PDE_OFS_DST_U: r_nxt.rdata = r_r.dst[15:8];
                pde_pkg::PDE_OFS_IO_L: r_nxt.rdata = r_r.ioa[7:0];
                pde_pkg::PDE_OFS_IO_U: r_nxt.rdata = r_r.ioa[15:8];
                pde_pkg::PDE_OFS_LEN_L: r_nxt.rdata = r_r.len[7:0];
                pde_pkg::PDE_OFS_LEN_H:
                    r_nxt.rdata = {2'h0, r_r.len[13:8]};
                pde_pkg::PDE_OFS_PROG_L: r_nxt.rdata = r_r.prog[7:0];
                pde_pkg::PDE_OFS_PROG_H:
                    r_nxt.rdata = {2'h0, r_r.prog[13:8]};
                pde_pkg::PDE_OFS_DATA:
                    r_nxt.rdata = pop ? buf_mem[r_r.rd_idx] : r_r.data;
                pde_pkg::PDE_OFS_THRESH: r_nxt.rdata = {2'h0, r_r.thresh};
                default: r_nxt.rdata = 8'h00;
            endcase
        end
        // summary: new enabled event sets it, set beats a clear
        if (summary_clear_i) begin
            r_nxt.summary = 1'b0;
        end
        if (|(r_nxt.flag & ~r_r.flag & r_r.ien)) begin
            r_nxt.summary = 1'b1;
        end
        r_nxt.irq = r_nxt.summary && ie_global_i && ie_ext0_i;
        if (srst) begin
            r_nxt = '0;
            buf_we = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // buffer shadow has no reset; fill count guards every read
    always_ff @(posedge clk_i) begin
        if (buf_we) begin
            buf_mem[r_r.wr_idx] <= r_r.data;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_SRST_READS_ZERO: assert property (
        io_rd_i && io_addr_i == pde_pkg::PDE_OFS_CONTROL |=> !io_rdata_o[0])
        else $error("soft reset bit read back as one");
    AST_PROG_HIGH_READ: assert property (
        io_rd_i && io_addr_i == pde_pkg::PDE_OFS_PROG_H
        |=> io_rdata_o == {2'h0, $past(r_r.prog[13:8])})
        else $error("progress high byte wrong");
    AST_THRESH_READBACK: assert property (
        io_wr_i && io_addr_i == pde_pkg::PDE_OFS_THRESH && !io_rd_i
        ##1 io_rd_i && io_addr_i == pde_pkg::PDE_OFS_THRESH && !io_wr_i
        |=> io_rdata_o == {2'h0, $past(io_wdata_i[5:0], 2)})
        else $error("threshold did not read back");
    AST_DONE_AT_LENGTH: assert property (
        store_done && !srst && r_r.mode != pde_pkg::PDE_MODE_FIFO
        && r_r.prog + 14'h0001 == r_r.len
        |=> r_r.flag[pde_pkg::PDE_FLAG_DONE] && !busy_o)
        else $error("done not raised at programmed length");
    AST_PUSH_ONLY_DONE: assert property (
        r_r.mode == pde_pkg::PDE_MODE_PUSH && !io_wr_i
        |=> !$rose(r_r.flag[pde_pkg::PDE_FLAG_FULL])
        && !$rose(r_r.flag[pde_pkg::PDE_FLAG_DAVAIL]))
        else $error("push mode raised a buffer event");
    AST_FIFO_RUNS_ON: assert property (
        r_r.mode == pde_pkg::PDE_MODE_FIFO && busy_o && r_r.en
        && !r_r.stop && !io_wr_i |=> busy_o)
        else $error("fifo mode stopped on its own");
    AST_PULL_WRITES_MEM: assert property (
        r_r.phase == pde_pkg::PDE_ST_STORE && mem_o.req
        |-> mem_o.we && r_r.mode != pde_pkg::PDE_MODE_PUSH)
        else $error("store phase direction wrong");
    AST_START_LAUNCH: assert property (
        !busy_o && r_r.en && io_wr_i && io_addr_i == pde_pkg::PDE_OFS_ENABLE
        && io_wdata_i == 8'h01 && r_r.len != 14'h0000
        |=> r_r.phase == pde_pkg::PDE_ST_FETCH ##1 mem_o.req || per_o.req)
        else $error("start did not launch a transfer");
    AST_SUMMARY_SET_WINS: assert property (
        |(r_nxt.flag & ~r_r.flag & r_r.ien) && summary_clear_i && !srst
        |=> summary_event_o)
        else $error("summary event lost to clear");
    AST_IRQ_GATED: assert property (
        ext_int0_o |-> $past(ie_global_i) && $past(ie_ext0_i)
        && summary_event_o)
        else $error("interrupt passed a closed gate");
endmodule

// ---- pde_far_model.sv ----
// far side of the engine: byte memory with a settable ack delay, paced port
module pde_far_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire pde_pkg::pde_mem_s mem_i,
    output logic mem_ack_o,
    output logic [7:0] mem_rdata_o,
    input wire pde_pkg::pde_io_s per_i,
    output logic [7:0] per_rdata_o,
    input wire logic [4:0] ready_i,
    input wire logic [3:0] sel_i,
    output logic [4:0] flow_ready_o,
    input wire logic [1:0] delay_i,
    output logic [7:0] per_cnt_o,
    output logic [7:0] per_last_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [1:0] wait_r;
    logic per_done;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h3c;
        end
    end
    assign flow_ready_o = ready_i;
    // only the peripheral that is really selected completes; 5 and up never
    assign per_done = per_i.req && sel_i < 4'h5 && ready_i[sel_i[2:0]];
    // off-cycle values are inverted so a stale sample cannot pass
    assign mem_rdata_o = mem_ack_o ? mem[mem_i.addr[7:0]]
                                   : ~mem[mem_i.addr[7:0]];
    assign per_rdata_o = (per_i.req && !per_i.we) ? 8'h50 + per_cnt_o
                                                  : ~(8'h50 + per_cnt_o);
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_ack_o <= 1'b0;
            wait_r <= 2'h0;
            per_cnt_o <= 8'h00;
            per_last_o <= 8'h00;
        end else begin
            mem_ack_o <= 1'b0;
            if (mem_ack_o) begin
                wait_r <= 2'h0;
                if (mem_i.we) begin
                    mem[mem_i.addr[7:0]] <= mem_i.wdata;
                end
            end else if (mem_i.req) begin
                if (wait_r == delay_i) begin
                    mem_ack_o <= 1'b1;
                end else begin
                    wait_r <= wait_r + 2'h1;
                end
            end
            if (per_done) begin
                per_cnt_o <= per_cnt_o + 8'h01;
                if (per_i.we) begin
                    per_last_o <= per_i.wdata;
                end
            end
        end
    end
endmodule

// ---- pde_engine_tb.sv ----
// self-checking bench for the dma engine: register map and transfer modes
module pde_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, reset_n_i, io_wr_i, io_rd_i, mem_ack_i, ie_global_i;
    logic ie_ext0_i, summary_clear_i, summary_event_o, ext_int0_o, busy_o;
    logic [3:0] io_addr_i, sel;
    logic [7:0] io_wdata_i, io_rdata_o, mem_rdata_i, per_rdata_i, pcnt, plast;
    logic [4:0] flow_ready_i, ready;
    logic [1:0] dly;
    pde_pkg::pde_mem_s mem_o;
    pde_pkg::pde_io_s per_o;
    int n_errors, n_tests;
    // time each strobe last fell; a repeat of the same strobe waits an edge
    time t_wr, t_rd;
    pde_engine u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i), .per_o(per_o), .per_rdata_i(per_rdata_i),
        .flow_ready_i(flow_ready_i), .ie_global_i(ie_global_i),
        .ie_ext0_i(ie_ext0_i), .summary_clear_i(summary_clear_i),
        .summary_event_o(summary_event_o), .ext_int0_o(ext_int0_o),
        .busy_o(busy_o));
    pde_far_model u_far (.clk_i(clk_i), .reset_n_i(reset_n_i), .mem_i(mem_o),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .per_i(per_o),
        .per_rdata_o(per_rdata_i), .ready_i(ready), .sel_i(sel),
        .flow_ready_o(flow_ready_i), .delay_i(dly), .per_cnt_o(pcnt),
        .per_last_o(plast));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        if (t_wr == $time) begin
            cyc(1);
        end
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        cyc(1);
        io_wr_i = 1'b0;
        t_wr = $time;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        if (t_rd == $time) begin
            cyc(1);
        end
        io_addr_i = a;
        io_rd_i = 1'b1;
        cyc(1);
        io_rd_i = 1'b0;
        t_rd = $time;
        chk(io_rdata_o, exp);
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 600 && busy_o !== 1'b0; n++) begin
            cyc(1);
        end
        chk({7'h00, busy_o}, 8'h00);
    endtask
    task automatic start(input logic [7:0] ena, srl, dsl, iou, len, th);
        wr(4'h0, 8'h01);
        wr(4'h2, ena);
        wr(4'h0, 8'h02);
        wr(4'hb, 8'h00);
        wr(4'ha, len);
        wr(4'h5, 8'h00);
        wr(4'h4, srl);
        wr(4'h7, 8'h00);
        wr(4'h6, dsl);
        wr(4'h9, iou);
        wr(4'h8, 8'h00);
        wr(4'hf, th);
        wr(4'h1, 8'h01);
    endtask
    task automatic close_out();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // generous bound: the whole sequence needs well under 1000 cycles
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
    initial begin
        reset_n_i = 1'b0;
        {io_wr_i, io_rd_i, summary_clear_i} = 3'h0;
        io_addr_i = 4'h0;
        io_wdata_i = 8'h00;
        {ie_global_i, ie_ext0_i} = 2'h3;
        {ready, sel, dly} = 11'h000;
        n_errors = 0;
        t_wr = 0;
        t_rd = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_i);
        #2 reset_n_i = 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), 8'h00);
        end
        wr(4'hb, 8'hff);
        rd(4'hb, 8'h3f);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h3f);
        wr(4'he, 8'ha5);
        rd(4'he, 8'ha5);
        wr(4'h2, 8'hff);
        rd(4'h2, 8'h7f);
        wr(4'hc, 8'h77);
        rd(4'hc, 8'h00);
        wr(4'h0, 8'h03);
        rd(4'h0, 8'h00);
        rd(4'hb, 8'h00);
        // push, slow memory, uart pacing only
        ready = 5'h01;
        dly = 2'h2;
        start(8'h01, 8'h10, 8'h00, 8'h00, 8'h03, 8'h00);
        cyc(4);
        chk(busy_o, 8'h01);
        chk(summary_event_o, 8'h00);
        wait_idle();
        chk(pcnt, 8'h03);
        chk(plast, 8'h2e);
        chk(summary_event_o, 8'h01);
        rd(4'hc, 8'h03);
        rd(4'hd, 8'h00);
        rd(4'h3, 8'h01);
        chk(ext_int0_o, 8'h01);
        wr(4'h3, 8'h01);
        rd(4'h3, 8'h00);
        summary_clear_i = 1'b1;
        cyc(1);
        summary_clear_i = 1'b0;
        chk(summary_event_o, 8'h00);
        cyc(1);
        chk(ext_int0_o, 8'h00);
        // pull from spi slave into memory
        {sel, ready, dly} = {4'h2, 5'h04, 2'h0};
        start(8'h09, 8'h00, 8'h40, 8'h20, 8'h02, 8'h00);
        wait_idle();
        chk(u_far.mem[8'h40], 8'h53);
        chk(u_far.mem[8'h41], 8'h54);
        rd(4'h3, 8'h01);
        // memory copy with the global enable off
        ie_global_i = 1'b0;
        start(8'h11, 8'h10, 8'h80, 8'h00, 8'h02, 8'h00);
        wait_idle();
        chk(u_far.mem[8'h80], 8'h2c);
        chk(u_far.mem[8'h81], 8'h2d);
        chk(summary_event_o, 8'h01);
        cyc(1);
        chk(ext_int0_o, 8'h00);
        ie_global_i = 1'b1;
        // fifo reception from the dma fifo, threshold 2
        {sel, ready} = {4'h4, 5'h10};
        start(8'h1c, 8'h00, 8'hc0, 8'h40, 8'h00, 8'h02);
        cyc(30);
        chk(busy_o, 8'h01);
        rd(4'h3, 8'h04);
        chk(u_far.mem[8'hc0], 8'h55);
        rd(4'he, 8'h55);
        // 64-byte buffer fills after 65 stores, less the one byte popped
        cyc(200);
        rd(4'h3, 8'h06);
        wr(4'h1, 8'h02);
        wait_idle();
        chk(busy_o, 8'h00);
        // unused selector never paces, soft reset frees the engine
        {sel, ready} = {4'h5, 5'h1f};
        start(8'h01, 8'h10, 8'h00, 8'h50, 8'h01, 8'h00);
        wr(4'h8, 8'h9a);
        cyc(20);
        chk(busy_o, 8'h01);
        rd(4'hc, 8'h00);
        chk(per_o.addr[7:0], 8'h9a);
        chk(per_o.wdata, 8'h2c);
        wr(4'h0, 8'h01);
        chk(busy_o, 8'h00);
        rd(4'h0, 8'h00);
        close_out();
    end
endmodule
